// ---- jtag_prog_defs.svh ----
// Constants for the scan-port programming block: instruction codes, widths, signature, timing.
// Assumes inclusion by both ends and by the package; holds definitions only.
`ifndef JTAG_PROG_DEFS_SVH
`define JTAG_PROG_DEFS_SVH
`define IR_W            4
`define INSTR_RESET     4'hc
`define INSTR_UNLOCK    4'h4
`define INSTR_COMMAND   4'h5
`define INSTR_PAGE_LD   4'h6
`define INSTR_PAGE_RD   4'h7
`define INSTR_BYPASS    4'hf
`define UNLOCK_W        16
`define UNLOCK_SIG      16'ha370
`define CMD_W           15
`define PAGE_BITS       2048
`define PAGE_RD_BITS    2056
`define PAGE_BYTES      256
`define JTD_CLR_CYCLES  2
`define RST_TIMEOUT_CYC 64
`define TCK_DIV         3
`endif

// ---- jtag_prog_pkg.sv ----
// Types shared by both ends of the scan-port programming link.
// Assumes the defines header is in the include path.
`include "jtag_prog_defs.svh"
package jtag_prog_pkg;
   typedef enum logic [15:0] {
      TLR  = 16'h0001, RTI  = 16'h0002, SDRS = 16'h0004, CDR  = 16'h0008,
      SDR  = 16'h0010, E1DR = 16'h0020, PDR  = 16'h0040, E2DR = 16'h0080,
      UDR  = 16'h0100, SIRS = 16'h0200, CIR  = 16'h0400, SIR  = 16'h0800,
      E1IR = 16'h1000, PIR  = 16'h2000, E2IR = 16'h4000, UIR  = 16'h8000
   } tap_state_t;
   typedef logic [`IR_W-1:0] instr_t;
   typedef logic [`CMD_W-1:0] cmd_t;
endpackage

// ---- jtag_prog_if.sv ----
// Four-pin scan port between programmer and device.
// Assumes the programmer drives tck, tms, tdi; the device drives tdo with enable.
`timescale 1ns/1ps
interface jtag_prog_if;
   logic tck;
   logic tms;
   logic tdi;
   logic tdo;
   logic tdo_oe;
   modport device (input tck, input tms, input tdi, output tdo, output tdo_oe);
   modport host   (output tck, output tms, output tdi, input tdo, input tdo_oe);
endinterface

// ---- jtag_prog_device.sv ----
// Device end: TAP controller and programming data registers, clocked by the link clock.
// Assumes SYS_CLK_I is the chip clock; array side is a plain port group on the chip clock.
`timescale 1ns/1ps
`include "jtag_prog_defs.svh"
module jtag_prog_device (
   jtag_prog_if.device                 LINK,
   input  wire logic                   SYS_CLK_I,
   input  wire logic                   SYS_RST_I,
   input  wire logic                   SCAN_PORT_ENABLE_FUSE_I,
   input  wire logic                   EXT_RESET_N_I,
   input  wire logic                   SCAN_PORT_DISABLE_SET_I,
   input  wire jtag_prog_pkg::cmd_t    CMD_RESULT_I,
   input  wire logic [7:0]             PAGE_RD_DATA_I,
   output logic                        SCAN_PORT_DISABLE_BIT_O,
   output logic                        CHIP_RESET_O,
   output logic                        PROG_ENABLED_O,
   output jtag_prog_pkg::cmd_t         CMD_O,
   output logic                        CMD_EXEC_O,
   output logic [7:0]                  PAGE_WR_DATA_O,
   output logic                        PAGE_WR_O,
   output logic [7:0]                  PAGE_ADDR_O,
   output logic                        PAGE_RD_O
);
   import jtag_prog_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Chip-clock side: disable bit and scan port enable
   logic       disable_r;
   logic [1:0] rst_low_cnt_r;
   logic       port_en_s1_r;
   logic       port_en_s2_r;
   logic       ext_rst_s1_r;
   logic       ext_rst_s2_r;
   wire        port_en = SCAN_PORT_ENABLE_FUSE_I & ~disable_r;
   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         disable_r     <= 1'b0;
         rst_low_cnt_r <= 2'h0;
      end else if (SCAN_PORT_DISABLE_SET_I) begin
         disable_r     <= 1'b1;
         rst_low_cnt_r <= 2'h0;
      end else if (disable_r && ext_rst_s2_r) begin
         // Reclaim path; not safe with boundary scan or debug in use
         if (rst_low_cnt_r == 2'(`JTD_CLR_CYCLES - 1)) begin
            disable_r <= 1'b0;
         end
         rst_low_cnt_r <= rst_low_cnt_r + 2'h1;
      end else begin
         rst_low_cnt_r <= 2'h0;
      end
   end
   assign SCAN_PORT_DISABLE_BIT_O = disable_r;

   ////////////////////////////////////////////////////////////////////////////
   // Link clock side: TAP controller
   tap_state_t st_r;
   tap_state_t st_nxt;
   logic       port_en_tck;
   always_ff @(posedge LINK.tck) begin
      port_en_s1_r <= port_en;
      port_en_s2_r <= port_en_s1_r;
   end
   assign port_en_tck = port_en_s2_r;
   always_comb begin
      case (st_r)
         TLR:     st_nxt = LINK.tms ? TLR  : RTI;
         RTI:     st_nxt = LINK.tms ? SDRS : RTI;
         SDRS:    st_nxt = LINK.tms ? SIRS : CDR;
         CDR:     st_nxt = LINK.tms ? E1DR : SDR;
         SDR:     st_nxt = LINK.tms ? E1DR : SDR;
         E1DR:    st_nxt = LINK.tms ? UDR  : PDR;
         PDR:     st_nxt = LINK.tms ? E2DR : PDR;
         E2DR:    st_nxt = LINK.tms ? UDR  : SDR;
         UDR:     st_nxt = LINK.tms ? SDRS : RTI;
         SIRS:    st_nxt = LINK.tms ? TLR  : CIR;
         CIR:     st_nxt = LINK.tms ? E1IR : SIR;
         SIR:     st_nxt = LINK.tms ? E1IR : SIR;
         E1IR:    st_nxt = LINK.tms ? UIR  : PIR;
         PIR:     st_nxt = LINK.tms ? E2IR : PIR;
         E2IR:    st_nxt = LINK.tms ? UIR  : SIR;
         UIR:     st_nxt = LINK.tms ? SDRS : RTI;
         default: st_nxt = TLR;
      endcase
   end

   instr_t           ir_sh_r;
   instr_t           ir_r;
   logic             rst_bit_r;
   logic [15:0]      unl_r;
   logic             unlocked_r;
   cmd_t             cmd_sh_r;
   cmd_t             cmd_r;
   logic             exec_tgl_r;
   logic [7:0]       pg_sh_r;
   logic [2:0]       bit_cnt_r;
   logic [7:0]       pg_addr_r;
   logic [7:0]       pg_wr_addr_r;
   logic             pg_tgl_r;
   logic             byp_r;
   logic             tdo_r;
   logic             tdo_oe_r;
   cmd_t             res_s1_r;
   cmd_t             res_s2_r;
   logic [7:0]       rd_s1_r;
   logic [7:0]       rd_s2_r;

   wire sel_rst = (ir_r == `INSTR_RESET);
   wire sel_unl = (ir_r == `INSTR_UNLOCK);
   wire sel_cmd = (ir_r == `INSTR_COMMAND);
   wire sel_pld = (ir_r == `INSTR_PAGE_LD) && unlocked_r;
   wire sel_prd = (ir_r == `INSTR_PAGE_RD) && unlocked_r;
   wire in_sdr  = (st_r == SDR);
   wire byte_done = in_sdr && (bit_cnt_r == 3'h7);

   // Result words are quasi-static while the programmer shifts; two stages per bit
   always_ff @(posedge LINK.tck) begin
      res_s1_r <= CMD_RESULT_I;
      res_s2_r <= res_s1_r;
      rd_s1_r  <= PAGE_RD_DATA_I;
      rd_s2_r  <= rd_s1_r;
   end

   // The TAP is reset by the TMS path or by the port enable going low, never by the reset register
   always_ff @(posedge LINK.tck) begin
      if (!port_en_tck) begin
         st_r <= TLR;
      end else begin
         st_r <= st_nxt;
      end
   end

   always_ff @(posedge LINK.tck) begin
      if (st_r == TLR) begin
         ir_r <= `INSTR_BYPASS;
         ir_sh_r <= '0;
      end else if (st_r == CIR) begin
         ir_sh_r <= 4'h1;
      end else if (st_r == SIR) begin
         ir_sh_r <= {LINK.tdi, ir_sh_r[`IR_W-1:1]};
      end else if (st_r == UIR) begin
         ir_r <= ir_sh_r;
      end
   end

   // Unlock register survives TAP reset; only power-on reset or an update with a wrong signature clears it
   // Reset is asynchronous here because the link clock stands still during power-on reset
   always_ff @(posedge LINK.tck or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         unl_r      <= '0;
         unlocked_r <= 1'b0;
         rst_bit_r  <= 1'b0;
      end else begin
         if (in_sdr && sel_rst) begin
            rst_bit_r <= LINK.tdi;
         end
         if (in_sdr && sel_unl) begin
            unl_r <= {LINK.tdi, unl_r[`UNLOCK_W-1:1]};
         end
         if (st_r == UDR && sel_unl) begin
            unlocked_r <= (unl_r == `UNLOCK_SIG);
         end
      end
   end

   always_ff @(posedge LINK.tck or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         cmd_sh_r   <= '0;
         cmd_r      <= '0;
         exec_tgl_r <= 1'b0;
         pg_sh_r    <= '0;
         bit_cnt_r  <= 3'h0;
         pg_addr_r  <= 8'h00;
         pg_wr_addr_r <= 8'h00;
         pg_tgl_r   <= 1'b0;
         byp_r      <= 1'b0;
      end else begin
         byp_r <= LINK.tdi;
         if (st_r == CDR) begin
            bit_cnt_r <= 3'h0;
            pg_addr_r <= 8'h00;
            if (sel_cmd) begin
               cmd_sh_r <= res_s2_r;
            end
            if (sel_prd) begin
               pg_sh_r <= 8'h00; // Leading dummy byte of the read chain
            end
         end
         if (in_sdr && sel_cmd) begin
            cmd_sh_r <= {LINK.tdi, cmd_sh_r[`CMD_W-1:1]};
         end
         if (st_r == UDR && sel_cmd && unlocked_r) begin
            cmd_r <= cmd_sh_r;
         end
         if (st_r == RTI && sel_cmd && unlocked_r) begin
            exec_tgl_r <= ~exec_tgl_r;
         end
         if (in_sdr && (sel_pld || sel_prd)) begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (sel_pld) begin
               pg_sh_r <= {LINK.tdi, pg_sh_r[7:1]};
            end else begin
               pg_sh_r <= byte_done ? rd_s2_r : {1'b0, pg_sh_r[7:1]};
            end
            if (byte_done) begin
               pg_tgl_r <= ~pg_tgl_r;
               // Loaded byte keeps its own index; the running address has moved on
               pg_wr_addr_r <= pg_addr_r;
               if (sel_prd || pg_addr_r != 8'hff) begin
                  pg_addr_r <= pg_addr_r + 8'h01;
               end
            end
         end
      end
   end

   // Drive TDO on the falling edge
   always_ff @(negedge LINK.tck) begin
      tdo_oe_r <= (st_r == SDR) || (st_r == SIR);
      if (st_r == SIR) begin
         tdo_r <= ir_sh_r[0];
      end else if (sel_cmd) begin
         tdo_r <= cmd_sh_r[0];
      end else if (sel_unl) begin
         tdo_r <= unl_r[0];
      end else if (sel_rst) begin
         tdo_r <= rst_bit_r;
      end else if (sel_pld || sel_prd) begin
         tdo_r <= pg_sh_r[0];
      end else begin
         tdo_r <= byp_r;
      end
   end
   assign LINK.tdo    = tdo_r;
   assign LINK.tdo_oe = tdo_oe_r;

   ////////////////////////////////////////////////////////////////////////////
   // Crossing into the chip clock: reset level and event toggles
   logic [2:0] rst_sync_r;
   logic [2:0] exec_sync_r;
   logic [2:0] pg_sync_r;
   logic       unl_s1_r;
   logic       unl_s2_r;
   logic [6:0] timeout_r;
   always_ff @(posedge SYS_CLK_I) begin
      rst_sync_r   <= {rst_sync_r[1:0], rst_bit_r};
      exec_sync_r  <= {exec_sync_r[1:0], exec_tgl_r};
      pg_sync_r    <= {pg_sync_r[1:0], pg_tgl_r};
      unl_s1_r     <= unlocked_r;
      unl_s2_r     <= unl_s1_r;
      ext_rst_s1_r <= ~EXT_RESET_N_I;
      ext_rst_s2_r <= ext_rst_s1_r;
   end
   wire hold_rst = rst_sync_r[1] | ext_rst_s2_r;
   // Short fixed time-out stands in for the fuse-selected start-up delay
   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I || hold_rst) begin
         timeout_r <= 7'(`RST_TIMEOUT_CYC);
      end else if (timeout_r != 7'h00) begin
         timeout_r <= timeout_r - 7'h01;
      end
   end
   assign CHIP_RESET_O = hold_rst | (timeout_r != 7'h00);

   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         CMD_EXEC_O     <= 1'b0;
         PAGE_WR_O      <= 1'b0;
         PAGE_RD_O      <= 1'b0;
         CMD_O          <= '0;
         PAGE_WR_DATA_O <= 8'h00;
         PAGE_ADDR_O    <= 8'h00;
         PROG_ENABLED_O <= 1'b0;
      end else begin
         PROG_ENABLED_O <= unl_s2_r;
         CMD_EXEC_O     <= exec_sync_r[2] ^ exec_sync_r[1];
         // Command word is stable a TCK before its toggle; page words change on the toggle's own TCK edge
         CMD_O          <= cmd_r;
         PAGE_WR_O      <= (pg_sync_r[2] ^ pg_sync_r[1]) & (ir_r == `INSTR_PAGE_LD);
         PAGE_RD_O      <= (pg_sync_r[2] ^ pg_sync_r[1]) & (ir_r == `INSTR_PAGE_RD);
         PAGE_WR_DATA_O <= pg_sh_r;
         PAGE_ADDR_O    <= (ir_r == `INSTR_PAGE_LD) ? pg_wr_addr_r : pg_addr_r;
      end
   end
endmodule

// ---- jtag_prog_host.sv ----
// Programmer end: derives TCK from the chip clock and runs IR, DR and idle scans.
// Assumes the caller waits for DONE before the next request; device is first in chain.
`timescale 1ns/1ps
`include "jtag_prog_defs.svh"
module jtag_prog_host (
   jtag_prog_if.host                   LINK,
   input  wire logic                   SYS_CLK_I,
   input  wire logic                   SYS_RST_I,
   input  wire logic                   START_I,
   input  wire logic                   IS_IR_I,
   input  wire logic                   IDLE_ONLY_I,
   input  wire logic                   RESET_TAP_I,
   input  wire logic [11:0]            LEN_I,
   input  wire logic [15:0]            DATA_I,
   output logic                        BUSY_O,
   output logic                        DONE_O,
   output logic [15:0]                 DATA_O
);
   import jtag_prog_pkg::*;

   typedef enum logic [5:0] {
      H_IDLE = 6'h01, H_SEL = 6'h02, H_SHIFT = 6'h04, H_EXIT = 6'h08,
      H_RUN = 6'h10, H_RST = 6'h20
   } host_state_t;

   host_state_t hs_r;
   logic [1:0]  div_r;
   logic        tck_r;
   logic        tms_r;
   logic        tdi_r;
   logic [2:0]  step_r;
   logic [11:0] cnt_r;
   logic [15:0] sh_r;
   logic        tdo_s1_r;
   logic        tdo_s2_r;

   // TCK low-to-high half periods; change outputs at fall, sample TDO at rise
   wire rise = (div_r == 2'(`TCK_DIV - 1)) && !tck_r;
   wire fall = (div_r == 2'(`TCK_DIV - 1)) && tck_r;

   always_ff @(posedge SYS_CLK_I) begin
      tdo_s1_r <= LINK.tdo;
      tdo_s2_r <= tdo_s1_r;
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         div_r <= 2'h0;
         tck_r <= 1'b0;
      end else if (hs_r == H_IDLE) begin
         div_r <= 2'h0;
         tck_r <= 1'b0;
      end else if (div_r == 2'(`TCK_DIV - 1)) begin
         div_r <= 2'h0;
         tck_r <= ~tck_r;
      end else begin
         div_r <= div_r + 2'h1;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         hs_r   <= H_IDLE;
         tms_r  <= 1'b1;
         tdi_r  <= 1'b0;
         step_r <= 3'h0;
         cnt_r  <= 12'h000;
         sh_r   <= 16'h0000;
         DONE_O <= 1'b0;
         DATA_O <= 16'h0000;
      end else begin
         DONE_O <= 1'b0;
         case (hs_r)
            H_IDLE: begin
               step_r <= 3'h0;
               if (START_I) begin
                  sh_r  <= DATA_I;
                  cnt_r <= LEN_I;
                  if (RESET_TAP_I) begin
                     hs_r  <= H_RST;
                     tms_r <= 1'b1;
                  end else if (IDLE_ONLY_I) begin
                     hs_r  <= H_RUN;
                     tms_r <= 1'b0;
                  end else begin
                     hs_r  <= H_SEL;
                     tms_r <= 1'b1;
                  end
               end
            end
            H_RST: begin
               // Five ones reach Test-Logic-Reset, then a zero parks in idle
               if (fall) begin
                  step_r <= step_r + 3'h1;
                  tms_r  <= (step_r < 3'h4);
                  if (step_r == 3'h5) begin
                     hs_r   <= H_IDLE;
                     DONE_O <= 1'b1;
                  end
               end
            end
            H_SEL: begin
               // From idle: 1 to Select-DR, [1 to Select-IR], 0 capture, 0 shift
               if (fall) begin
                  step_r <= step_r + 3'h1;
                  case (step_r)
                     3'h0:    tms_r <= IS_IR_I;
                     3'h1:    tms_r <= IS_IR_I ? 1'b0 : 1'b0;
                     3'h2:    tms_r <= 1'b0;
                     default: tms_r <= 1'b0;
                  endcase
                  if (step_r == (IS_IR_I ? 3'h3 : 3'h2)) begin
                     hs_r  <= H_SHIFT;
                     tdi_r <= sh_r[0];
                     tms_r <= (cnt_r == 12'h001);
                  end
               end
            end
            H_SHIFT: begin
               if (rise) begin
                  sh_r <= {tdo_s2_r, sh_r[15:1]};
               end
               if (fall) begin
                  cnt_r <= cnt_r - 12'h001;
                  tdi_r <= sh_r[0];
                  tms_r <= (cnt_r == 12'h002);
                  if (cnt_r == 12'h001) begin
                     hs_r   <= H_EXIT;
                     step_r <= 3'h0;
                     tms_r  <= 1'b1;
                  end
               end
            end
            H_EXIT: begin
               // Exit1 -> Update -> Run-Test/Idle
               if (fall) begin
                  step_r <= step_r + 3'h1;
                  tms_r  <= 1'b0;
                  if (step_r == 3'h1) begin
                     hs_r   <= H_IDLE;
                     DONE_O <= 1'b1;
                     DATA_O <= sh_r;
                  end
               end
            end
            H_RUN: begin
               // One TCK in Run-Test/Idle executes the applied command
               if (fall) begin
                  hs_r   <= H_IDLE;
                  DONE_O <= 1'b1;
               end
            end
            default: hs_r <= H_IDLE;
         endcase
      end
   end

   assign LINK.tck = tck_r;
   assign LINK.tms = tms_r;
   assign LINK.tdi = tdi_r;
   assign BUSY_O   = (hs_r != H_IDLE);
endmodule

// ---- jtag_prog_props.sv ----
// Wire-level checks on the scan-port link between programmer and device.
// Assumes the programmer makes tck from SYS_CLK_I and both ends reset on SYS_RST_I.
`timescale 1ns/1ps
module jtag_prog_props (
   input wire logic SYS_CLK_I,
   input wire logic SYS_RST_I,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic tdo,
   input wire logic tdo_oe
);
   import jtag_prog_pkg::*;
   ////////////////////////////////////////////////////////////////////////////////
   // Shadow TAP controller, follows tms as the device should
   tap_state_t st_r;
   tap_state_t st_nxt;
   logic [2:0] ir_cnt_r;
   logic [2:0] ir_cnt_nxt;
   assign ir_cnt_nxt = (st_r == SIR) ? ir_cnt_r + 3'h1 : 3'h0;
   always_comb begin
      case (st_r)
         TLR:     st_nxt = tms ? TLR  : RTI;
         RTI:     st_nxt = tms ? SDRS : RTI;
         SDRS:    st_nxt = tms ? SIRS : CDR;
         CDR:     st_nxt = tms ? E1DR : SDR;
         SDR:     st_nxt = tms ? E1DR : SDR;
         E1DR:    st_nxt = tms ? UDR  : PDR;
         PDR:     st_nxt = tms ? E2DR : PDR;
         E2DR:    st_nxt = tms ? UDR  : SDR;
         UDR:     st_nxt = tms ? SDRS : RTI;
         SIRS:    st_nxt = tms ? TLR  : CIR;
         CIR:     st_nxt = tms ? E1IR : SIR;
         SIR:     st_nxt = tms ? E1IR : SIR;
         E1IR:    st_nxt = tms ? UIR  : PIR;
         PIR:     st_nxt = tms ? E2IR : PIR;
         E2IR:    st_nxt = tms ? UIR  : SIR;
         UIR:     st_nxt = tms ? SDRS : RTI;
         default: st_nxt = TLR;
      endcase
   end
   // Async clear: tck stands still during reset, so a sync clear would never land
   always_ff @(posedge tck or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         st_r     <= TLR;
         ir_cnt_r <= 3'h0;
      end else begin
         st_r     <= st_nxt;
         ir_cnt_r <= ir_cnt_nxt;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   sequence s_hold_high;
      tck [*3] ##1 !tck;
   endsequence
   sequence s_hold_low;
      (!tck) [*3];
   endsequence
   property p_oe_shift;
      @(posedge tck) disable iff (SYS_RST_I) tdo_oe |-> (st_r == SDR || st_r == SIR);
   endproperty
   property p_idle_rest;
      @(posedge tck) disable iff (SYS_RST_I) (st_r == RTI || st_r == TLR) |-> !tdo_oe;
   endproperty
   property p_ir_len;
      @(posedge tck) disable iff (SYS_RST_I) (st_r == SIR && tms) |-> ir_cnt_r == 3'h3;
   endproperty
   property p_tdo_fall;
      @(posedge SYS_CLK_I) disable iff (SYS_RST_I) (tdo_oe && $changed(tdo)) |-> !tck;
   endproperty
   property p_tms_fall;
      @(posedge SYS_CLK_I) disable iff (SYS_RST_I) $changed(tms) |-> !tck;
   endproperty
   property p_tdi_fall;
      @(posedge SYS_CLK_I) disable iff (SYS_RST_I) $changed(tdi) |-> !tck;
   endproperty
   property p_tck_high;
      @(posedge SYS_CLK_I) disable iff (SYS_RST_I) $rose(tck) |-> s_hold_high;
   endproperty
   property p_tck_low;
      @(posedge SYS_CLK_I) disable iff (SYS_RST_I) $fell(tck) |-> s_hold_low;
   endproperty
   a_oe_shift: assert property (p_oe_shift) else $error("tdo driven outside a shift state");
   a_idle_rest: assert property (p_idle_rest) else $error("tdo driven while resting");
   a_ir_len: assert property (p_ir_len) else $error("instruction shift not four bits");
   a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved while tck high");
   a_tms_fall: assert property (p_tms_fall) else $error("tms moved while tck high");
   a_tdi_fall: assert property (p_tdi_fall) else $error("tdi moved while tck high");
   a_tck_high: assert property (p_tck_high) else $error("tck high phase not three clocks");
   a_tck_low: assert property (p_tck_low) else $error("tck low phase too short");
   c_low: cover property (@(posedge SYS_CLK_I) $fell(tck) ##0 s_hold_low);
endmodule

// ---- jtag_programming_port_tb.sv ----
// Self-checking bench: programmer end and device end joined by the scan-port interface.
// Assumes the host's LSB-first walk and a device that is first in the chain.
`timescale 1ns/1ps
`include "jtag_prog_defs.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
   $display("MISMATCH %s exp=%0h got=%0h", nm, e, g); end end
module jtag_programming_port_tb;
   import jtag_prog_pkg::*;
   localparam cmd_t CMD_RESULT = 15'h4c1d;
   logic        sys_clk, sys_rst, fuse, ext_rst_n, dis_set, start, is_ir, idle_only, rst_tap;
   logic [11:0] len;
   logic [15:0] din, data_o;
   logic        busy, done, dis_bit, chip_rst, prog_en, cmd_exec, page_wr, page_rd;
   cmd_t        cmd_o;
   logic [7:0]  page_wr_data, page_addr, page_rd_data;
   int          n_errors, cmp_count, oe_cnt, exec_cnt;
   logic [15:0] wr_q[$];
   ////////////////////////////////////////////////////////////////////////////////
   jtag_prog_if link ();
   jtag_prog_device jtag_prog_device_inst (.LINK(link), .SYS_CLK_I(sys_clk), .SYS_RST_I(sys_rst),
      .SCAN_PORT_ENABLE_FUSE_I(fuse), .EXT_RESET_N_I(ext_rst_n), .SCAN_PORT_DISABLE_SET_I(dis_set),
      .CMD_RESULT_I(CMD_RESULT), .PAGE_RD_DATA_I(page_rd_data), .SCAN_PORT_DISABLE_BIT_O(dis_bit),
      .CHIP_RESET_O(chip_rst), .PROG_ENABLED_O(prog_en), .CMD_O(cmd_o), .CMD_EXEC_O(cmd_exec),
      .PAGE_WR_DATA_O(page_wr_data), .PAGE_WR_O(page_wr), .PAGE_ADDR_O(page_addr), .PAGE_RD_O(page_rd));
   jtag_prog_host jtag_prog_host_inst (.LINK(link), .SYS_CLK_I(sys_clk), .SYS_RST_I(sys_rst),
      .START_I(start), .IS_IR_I(is_ir), .IDLE_ONLY_I(idle_only), .RESET_TAP_I(rst_tap), .LEN_I(len),
      .DATA_I(din), .BUSY_O(busy), .DONE_O(done), .DATA_O(data_o));
   jtag_prog_props jtag_prog_props_inst (.SYS_CLK_I(sys_clk), .SYS_RST_I(sys_rst), .tck(link.tck),
      .tms(link.tms), .tdi(link.tdi), .tdo(link.tdo), .tdo_oe(link.tdo_oe));
   // Page contents that cannot be mistaken for a shifted copy of the address
   assign page_rd_data = page_addr ^ 8'h3c;
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (link.tdo_oe === 1'b1) oe_cnt++;
      if (cmd_exec === 1'b1) exec_cnt++;
      if (page_wr === 1'b1) wr_q.push_back({page_addr, page_wr_data});
   end
   task automatic give_verdict;
      if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic scan(input logic ir, input logic idle, input logic rtap, input logic [11:0] n,
                       input logic [15:0] d);
      int i;
      @(negedge sys_clk);
      {is_ir, idle_only, rst_tap, len, din} = {ir, idle, rtap, n, d};
      start = 1'b1;
      @(negedge sys_clk);
      start = 1'b0;
      for (i = 0; i < 4000; i++) begin
         @(negedge sys_clk);
         if (done === 1'b1) break;
      end
      if (i == 4000) begin
         n_errors++;
         give_verdict;
      end
   endtask
   task automatic ir(input logic [3:0] c);
      scan(1'b1, 1'b0, 1'b0, 12'd4, {12'h000, c});
   endtask
   task automatic dr(input logic [11:0] n, input logic [15:0] d);
      scan(1'b0, 1'b0, 1'b0, n, d);
   endtask
   initial begin
      repeat (60000) @(posedge sys_clk);
      n_errors++;
      give_verdict;
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {sys_rst, fuse, ext_rst_n, dis_set, start, is_ir, idle_only, rst_tap} = 8'b01100000;
      #1 sys_rst = 1'b1;
      len = 12'h000;
      din = 16'h0000;
      repeat (8) @(posedge sys_clk);
      @(negedge sys_clk);
      sys_rst = 1'b0;
      `CHK("prog_enabled", 1'b0, prog_en)
      `CHK("disable_bit", 1'b0, dis_bit)
      scan(1'b0, 1'b0, 1'b1, 12'd0, 16'h0000);
      dis_set = 1'b1;
      @(negedge sys_clk);
      dis_set = 1'b0;
      oe_cnt = 0;
      dr(12'd8, 16'h00a5);
      `CHK("oe_disabled", 0, oe_cnt)
      ext_rst_n = 1'b0;
      @(negedge sys_clk);
      `CHK("disable_bit_1clk", 1'b1, dis_bit)
      repeat (3) @(negedge sys_clk);
      `CHK("disable_bit_2clk", 1'b0, dis_bit)
      ext_rst_n = 1'b1;
      fuse = 1'b0;
      oe_cnt = 0;
      dr(12'd8, 16'h00a5);
      `CHK("oe_no_fuse", 0, oe_cnt)
      fuse = 1'b1;
      scan(1'b0, 1'b0, 1'b1, 12'd0, 16'h0000);
      ir(`INSTR_RESET);
      dr(12'd1, 16'h0001);
      `CHK("chip_reset_set", 1'b1, chip_rst)
      oe_cnt = 0;
      dr(12'd1, 16'h0000);
      `CHK("chip_reset_hold", 1'b1, chip_rst)
      `CHK("oe_enabled", 1'b1, oe_cnt > 0)
      repeat (80) @(negedge sys_clk);
      `CHK("chip_reset_free", 1'b0, chip_rst)
      exec_cnt = 0;
      ir(`INSTR_COMMAND);
      dr(12'd15, 16'h0123);
      scan(1'b0, 1'b1, 1'b0, 12'd0, 16'h0000);
      @(negedge sys_clk);
      `CHK("exec_locked", 0, exec_cnt)
      ir(`INSTR_UNLOCK);
      dr(12'd16, 16'ha371);
      `CHK("unlock_bad", 1'b0, prog_en)
      dr(12'd16, `UNLOCK_SIG);
      `CHK("unlock_good", 1'b1, prog_en)
      ir(`INSTR_COMMAND);
      dr(12'd15, 16'h2a5b);
      `CHK("cmd_applied", 15'h2a5b, cmd_o)
      `CHK("cmd_result", CMD_RESULT, data_o[15:1])
      exec_cnt = 0;
      repeat (2) scan(1'b0, 1'b1, 1'b0, 12'd0, 16'h0000);
      @(negedge sys_clk);
      `CHK("exec_count", 2, exec_cnt)
      ir(`INSTR_PAGE_LD);
      dr(12'd16, 16'h5ac3);
      `CHK("page_wr_count", 2, wr_q.size())
      `CHK("page_wr_0", 16'h00c3, wr_q[0])
      `CHK("page_wr_1", 16'h015a, wr_q[1])
      ir(`INSTR_PAGE_RD);
      dr(12'd16, 16'h0000);
      `CHK("page_rd_a", 16'h3c00, data_o)
      dr(12'd16, 16'hffff);
      `CHK("page_rd_b", 16'h3c00, data_o)
      give_verdict;
   end
endmodule
